// file: acss_defs.svh
// Bit positions, field codes and reset values of the command and scan sequencer
`ifndef ACSS_DEFS_SVH
`define ACSS_DEFS_SVH

// ------------------------------------------------------------
// Command byte layout
// ------------------------------------------------------------
`define ACSS_CMD_MARK_BIT   7
`define ACSS_CMD_TYPE_BIT   6
`define ACSS_CMD_OP_HI      5
`define ACSS_CMD_OP_LO      4
`define ACSS_CMD_RATE_HI    3
`define ACSS_CMD_RATE_LO    0
`define ACSS_CMD_IDX_HI     5
`define ACSS_CMD_IDX_LO     1
`define ACSS_CMD_DIR_BIT    0
`define ACSS_DIR_READ       1'b1

// ------------------------------------------------------------
// Scan setup and control field codes
// ------------------------------------------------------------
`define ACSS_SCAN_SINGLE    2'h0
`define ACSS_SCAN_MULTI     2'h1
`define ACSS_PD_STANDBY     2'h2

// ------------------------------------------------------------
// Low-power report codes
// ------------------------------------------------------------
`define ACSS_LPR_CONV       2'h0
`define ACSS_LPR_SLEEP      2'h1
`define ACSS_LPR_STANDBY    2'h2

// ------------------------------------------------------------
// Order slots and reset values
// ------------------------------------------------------------
`define ACSS_SLOT_NONE      3'h0
`define ACSS_SLOT_BAD       3'h7
`define ACSS_RATE_RST       4'h0
`define ACSS_DELAY_ZERO     8'h00

`endif

// file: acss_pkg.sv
// Types shared by the command and scan sequencer modules
package acss_pkg;

   // Operation selector of a conversion command
   typedef enum logic [1:0] {
      ACSS_OP_NONE  = 2'h0,
      ACSS_OP_PDOWN = 2'h1,
      ACSS_OP_CAL   = 2'h2,
      ACSS_OP_SEQ   = 2'h3
   } acss_op_t;

   // Sequencer states, Gray along sleep, settle, convert, back
   typedef enum logic [2:0] {
      ACSS_ST_SLEEP   = 3'h0,
      ACSS_ST_SETTLE  = 3'h1,
      ACSS_ST_CONV    = 3'h3,
      ACSS_ST_STANDBY = 3'h2,
      ACSS_ST_CAL     = 3'h6
   } acss_state_t;

endpackage

// file: acss_dly_if.sv
// Handshake between the sequencer and its settle delay timer
`timescale 1ns/1ps
interface acss_dly_if;
   logic       start;
   logic [7:0] length;
   logic       done;

   modport ctrl  (output start, output length, input done);
   modport timer (input start, input length, output done);
endinterface

// file: acss_settle_timer.sv
// Input settling delay timer, counted in ticks of a programmable cycle count
`timescale 1ns/1ps
`include "acss_defs.svh"
module acss_settle_timer #(
   parameter int TICK_CYCLES = 1
) (
   // Clock and reset
   input wire logic CLK,
   input wire logic RST_B,
   // Sequencer side
   acss_dly_if.timer dly
);
   import acss_pkg::*;

   localparam int CW = 8 + $clog2(TICK_CYCLES + 1) + 1;

   logic [CW-1:0] cnt_r;
   logic [CW-1:0] cnt_nxt;
   logic          busy_r;
   logic          busy_nxt;
   logic          done_r;
   logic          done_nxt;

   // ------------------------------------------------------------
   // Countdown; a zero length still answers one cycle after start
   // ------------------------------------------------------------
   always_comb begin
      cnt_nxt  = cnt_r;
      busy_nxt = busy_r;
      done_nxt = 1'b0;
      if (dly.start) begin
         if (dly.length == `ACSS_DELAY_ZERO) begin
            done_nxt = 1'b1;
            busy_nxt = 1'b0;
         end else begin
            cnt_nxt  = CW'(dly.length) * CW'(TICK_CYCLES);
            busy_nxt = 1'b1;
         end
      end else if (busy_r) begin
         cnt_nxt = cnt_r - CW'(1);
         if (cnt_r == CW'(1)) begin
            done_nxt = 1'b1;
            busy_nxt = 1'b0;
         end
      end
   end

   // Register stage
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         cnt_r  <= '0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         busy_r <= busy_nxt;
         done_r <= done_nxt;
      end
   end

   assign dly.done = done_r;

endmodule

// file: adc_command_and_scan_sequencer.sv
// Command byte decoder and conversion sequencer of a multichannel converter
`timescale 1ns/1ps
`include "acss_defs.svh"
module adc_command_and_scan_sequencer #(
   parameter int NCH         = 6,
   parameter int DATA_W      = 24,
   parameter int BIAS_PINS   = 2,
   parameter int TICK_CYCLES = 1
) (
   // Clock and reset
   input  wire logic                  CLK,
   input  wire logic                  RST_B,
   // Command bytes from the serial framing logic
   input  wire logic [7:0]            CMD_BYTE,
   input  wire logic                  CMD_VALID,
   // Scan setup configuration
   input  wire logic [1:0]            SCAN_MODE,
   input  wire logic [2:0]            INPUT_SELECTOR,
   input  wire logic                  SETTLE_DELAY_ENABLE,
   input  wire logic                  READY_AT_SCAN_END,
   input  wire logic [7:0]            MUX_DELAY,
   // Control register one fields
   input  wire logic                  ONE_SHOT_SELECT,
   input  wire logic                  REPEAT_ONE_SHOT,
   input  wire logic [1:0]            POWER_DOWN_EXIT_STATE,
   input  wire logic [1:0]            CAL_KIND,
   // Channel maps
   input  wire logic [3*NCH-1:0]      CHANNEL_ORDER_SLOT,
   input  wire logic [NCH-1:0]        CHANNEL_SCAN_ENABLE,
   // Bias pin control registers
   input  wire logic [BIAS_PINS-1:0]  BIAS_OUTPUT_DIRECTION,
   input  wire logic [BIAS_PINS-1:0]  BIAS_PIN_CONTROL,
   // Converter and calibration engine
   input  wire logic                  CONV_DONE,
   input  wire logic [DATA_W-1:0]     CONV_DATA,
   input  wire logic                  CAL_DONE,
   input  wire logic                  RESULT_READ,
   output      logic                  CONV_START,
   output      logic                  CONV_ABORT,
   output      logic [2:0]            ACTIVE_CHANNEL,
   output      logic [3:0]            CONV_RATE,
   output      logic                  CAL_START,
   output      logic [1:0]            CAL_KIND_OUT,
   // Register access requests
   output      logic [4:0]            REGISTER_INDEX,
   output      logic                  REG_WRITE,
   output      logic                  REG_READ,
   // Results and status
   output      logic [DATA_W-1:0]     RESULT_DATA,
   output      logic [NCH*DATA_W-1:0] CHANNEL_DATA,
   output      logic [NCH-1:0]        CHANNEL_DONE_FLAGS,
   output      logic                  RESULT_READY_N,
   output      logic [1:0]            LOW_POWER_REPORT,
   output      logic                  MODULATOR_BUSY,
   // Output bias pins
   output      logic [BIAS_PINS-1:0]  OUTPUT_BIAS_PIN,
   output      logic [BIAS_PINS-1:0]  OUTPUT_BIAS_PIN_OE
);
   import acss_pkg::*;

   // ------------------------------------------------------------
   // Next enabled channel after a slot: {found, channel, slot}
   // ------------------------------------------------------------
   function automatic logic [6:0] next_channel(input logic [2:0]       prev,
                                               input logic [3*NCH-1:0] ord,
                                               input logic [NCH-1:0]   en);
      logic       found;
      logic [2:0] best_ch;
      logic [2:0] best_slot;
      logic [2:0] s;
      found     = 1'b0;
      best_ch   = 3'h0;
      best_slot = `ACSS_SLOT_NONE;
      for (int i = 0; i < NCH; i++) begin
         s = ord[3*i +: 3];
         // Slots 000 and 111 are unusable and never scanned
         if (en[i] && s != `ACSS_SLOT_NONE && s != `ACSS_SLOT_BAD && s > prev &&
             (!found || s < best_slot)) begin
            found     = 1'b1;
            best_ch   = 3'(i);
            best_slot = s;
         end
      end
      return {found, best_ch, best_slot};
   endfunction

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   acss_dly_if dly ();

   acss_state_t       state_r;
   acss_state_t       state_nxt;
   logic [2:0]        ch_r;
   logic [2:0]        ch_nxt;
   logic [2:0]        slot_r;
   logic [2:0]        slot_nxt;
   logic              multi_r;
   logic              multi_nxt;
   logic [3:0]        rate_r;
   logic [3:0]        rate_nxt;
   logic [1:0]        cal_kind_r;
   logic [1:0]        cal_kind_nxt;
   logic              rdy_n_r;
   logic              rdy_n_nxt;
   logic [NCH-1:0]    done_r;
   logic [NCH-1:0]    done_nxt;
   logic [DATA_W-1:0] data_r;
   logic [DATA_W-1:0] data_nxt;
   logic [DATA_W-1:0] chan_r   [NCH];
   logic [DATA_W-1:0] chan_nxt [NCH];
   logic              start_r;
   logic              start_nxt;
   logic              abort_r;
   logic              abort_nxt;
   logic              cal_go_r;
   logic              cal_go_nxt;
   logic [4:0]        idx_r;
   logic [4:0]        idx_nxt;
   logic              wr_r;
   logic              wr_nxt;
   logic              rd_r;
   logic              rd_nxt;
   logic [1:0]        lpr_r;
   logic [1:0]        lpr_nxt;
   logic              busy_r;
   logic              busy_nxt;
   logic [BIAS_PINS-1:0] bias_r;
   logic [BIAS_PINS-1:0] bias_oe_r;

   logic              is_conv_cmd;
   logic              is_reg_cmd;
   acss_op_t          op;
   logic [6:0]        pick_next;
   logic [6:0]        pick_first;
   logic              chan_wr;
   logic [NCH-1:0]    done_set;
   acss_state_t       pd_target;
   logic              dly_go;

   // ------------------------------------------------------------
   // Command decode
   // ------------------------------------------------------------
   assign is_conv_cmd = CMD_VALID && CMD_BYTE[`ACSS_CMD_MARK_BIT] &&
                        !CMD_BYTE[`ACSS_CMD_TYPE_BIT];
   assign is_reg_cmd  = CMD_VALID && CMD_BYTE[`ACSS_CMD_MARK_BIT] &&
                        CMD_BYTE[`ACSS_CMD_TYPE_BIT];
   assign op          = acss_op_t'(CMD_BYTE[`ACSS_CMD_OP_HI:`ACSS_CMD_OP_LO]);
   assign pick_next   = next_channel(slot_r, CHANNEL_ORDER_SLOT, CHANNEL_SCAN_ENABLE);
   assign pick_first  = next_channel(`ACSS_SLOT_NONE, CHANNEL_ORDER_SLOT,
                                     CHANNEL_SCAN_ENABLE);
   // Exit state chosen beforehand; anything but standby means sleep
   assign pd_target   = (POWER_DOWN_EXIT_STATE == `ACSS_PD_STANDBY) ?
                        ACSS_ST_STANDBY : ACSS_ST_SLEEP;

   // Settle delay request; a disabled delay is a zero length
   assign dly.start  = dly_go;
   assign dly.length = SETTLE_DELAY_ENABLE ? MUX_DELAY : `ACSS_DELAY_ZERO;

   // ------------------------------------------------------------
   // Sequencer next state
   // ------------------------------------------------------------
   always_comb begin
      state_nxt    = state_r;
      ch_nxt       = ch_r;
      slot_nxt     = slot_r;
      multi_nxt    = multi_r;
      rate_nxt     = rate_r;
      cal_kind_nxt = cal_kind_r;
      rdy_n_nxt    = rdy_n_r;
      data_nxt     = data_r;
      start_nxt    = 1'b0;
      abort_nxt    = 1'b0;
      cal_go_nxt   = 1'b0;
      dly_go       = 1'b0;
      chan_wr      = 1'b0;
      done_set     = '0;
      done_nxt     = done_r;
      // Reading the result releases the ready line; a new result wins below
      if (RESULT_READ) begin
         rdy_n_nxt = 1'b1;
      end
      case (state_r)
         ACSS_ST_SETTLE: begin
            if (dly.done) begin
               state_nxt = ACSS_ST_CONV;
               start_nxt = 1'b1;
            end
         end
         ACSS_ST_CONV: begin
            if (CONV_DONE && !multi_r) begin
               data_nxt  = CONV_DATA;
               rdy_n_nxt = 1'b0;
               if (ONE_SHOT_SELECT && !REPEAT_ONE_SHOT) begin
                  state_nxt = ACSS_ST_SLEEP;
               end else begin
                  state_nxt = ACSS_ST_SETTLE;
                  dly_go    = 1'b1;
               end
            end else if (CONV_DONE) begin
               // Repeat bit plays no part in a scan
               chan_wr      = 1'b1;
               done_set[ch_r] = 1'b1;
               if (!READY_AT_SCAN_END || !pick_next[6]) begin
                  rdy_n_nxt = 1'b0;
               end
               if (pick_next[6]) begin
                  ch_nxt    = pick_next[5:3];
                  slot_nxt  = pick_next[2:0];
                  state_nxt = ACSS_ST_SETTLE;
                  dly_go    = 1'b1;
               end else begin
                  state_nxt = ACSS_ST_SLEEP;
               end
            end
         end
         ACSS_ST_CAL: begin
            if (CAL_DONE) begin
               state_nxt = pd_target;
            end
         end
         default: begin
         end
      endcase
      // Commands take priority over a conversion finishing in the same cycle
      if (is_conv_cmd) begin
         case (op)
            ACSS_OP_PDOWN: begin
               abort_nxt = (state_r == ACSS_ST_CONV) || (state_r == ACSS_ST_SETTLE);
               state_nxt = pd_target;
            end
            ACSS_OP_CAL: begin
               cal_kind_nxt = CAL_KIND;
               cal_go_nxt   = 1'b1;
               state_nxt    = ACSS_ST_CAL;
            end
            ACSS_OP_SEQ: begin
               rate_nxt  = CMD_BYTE[`ACSS_CMD_RATE_HI:`ACSS_CMD_RATE_LO];
               rdy_n_nxt = 1'b1;
               done_nxt  = '0;
               if (SCAN_MODE == `ACSS_SCAN_SINGLE) begin
                  multi_nxt = 1'b0;
                  ch_nxt    = INPUT_SELECTOR;
                  state_nxt = ACSS_ST_SETTLE;
                  dly_go    = 1'b1;
               end else begin
                  multi_nxt = 1'b1;
                  ch_nxt    = pick_first[5:3];
                  slot_nxt  = pick_first[2:0];
                  // An empty scan finishes at once
                  state_nxt = pick_first[6] ? ACSS_ST_SETTLE : ACSS_ST_SLEEP;
                  dly_go    = pick_first[6];
               end
            end
            default: begin
               // Unused selector: the state holds
               state_nxt = state_r;
            end
         endcase
      end
      // Flags set this cycle survive a clear in the same cycle
      done_nxt = done_nxt | done_set;
   end

   // ------------------------------------------------------------
   // Register access requests and status
   // ------------------------------------------------------------
   always_comb begin
      idx_nxt  = idx_r;
      wr_nxt   = 1'b0;
      rd_nxt   = 1'b0;
      if (is_reg_cmd) begin
         idx_nxt = CMD_BYTE[`ACSS_CMD_IDX_HI:`ACSS_CMD_IDX_LO];
         rd_nxt  = (CMD_BYTE[`ACSS_CMD_DIR_BIT] == `ACSS_DIR_READ);
         wr_nxt  = !rd_nxt;
      end
      case (state_nxt)
         ACSS_ST_SLEEP:   lpr_nxt = `ACSS_LPR_SLEEP;
         ACSS_ST_STANDBY: lpr_nxt = `ACSS_LPR_STANDBY;
         default:         lpr_nxt = `ACSS_LPR_CONV;
      endcase
      busy_nxt = (state_nxt == ACSS_ST_CONV);
   end

   // Per-channel result storage, written by channel index
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         chan_nxt[i] = (chan_wr && ch_r == 3'(i)) ? CONV_DATA : chan_r[i];
      end
   end

   // ------------------------------------------------------------
   // Register stages
   // ------------------------------------------------------------
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         state_r    <= ACSS_ST_SLEEP;
         ch_r       <= 3'h0;
         slot_r     <= `ACSS_SLOT_NONE;
         multi_r    <= 1'b0;
         rate_r     <= `ACSS_RATE_RST;
         cal_kind_r <= 2'h0;
         rdy_n_r    <= 1'b1;
         done_r     <= '0;
         data_r     <= '0;
         start_r    <= 1'b0;
         abort_r    <= 1'b0;
         cal_go_r   <= 1'b0;
         idx_r      <= 5'h00;
         wr_r       <= 1'b0;
         rd_r       <= 1'b0;
         lpr_r      <= `ACSS_LPR_SLEEP;
         busy_r     <= 1'b0;
         for (int i = 0; i < NCH; i++) begin
            chan_r[i] <= '0;
         end
      end else begin
         state_r    <= state_nxt;
         ch_r       <= ch_nxt;
         slot_r     <= slot_nxt;
         multi_r    <= multi_nxt;
         rate_r     <= rate_nxt;
         cal_kind_r <= cal_kind_nxt;
         rdy_n_r    <= rdy_n_nxt;
         done_r     <= done_nxt;
         data_r     <= data_nxt;
         start_r    <= start_nxt;
         abort_r    <= abort_nxt;
         cal_go_r   <= cal_go_nxt;
         idx_r      <= idx_nxt;
         wr_r       <= wr_nxt;
         rd_r       <= rd_nxt;
         lpr_r      <= lpr_nxt;
         busy_r     <= busy_nxt;
         for (int i = 0; i < NCH; i++) begin
            chan_r[i] <= chan_nxt[i];
         end
      end
   end

   // Bias pins follow their control registers in every mode; maps never steer them
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         bias_r    <= '0;
         bias_oe_r <= '0;
      end else begin
         bias_r    <= BIAS_PIN_CONTROL;
         bias_oe_r <= BIAS_OUTPUT_DIRECTION;
      end
   end

   // ------------------------------------------------------------
   // Settle delay timer and outputs
   // ------------------------------------------------------------
   acss_settle_timer #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_timer (
      .CLK   (CLK),
      .RST_B (RST_B),
      .dly   (dly.timer)
   );

   for (genvar g = 0; g < NCH; g++) begin : g_chan
      assign CHANNEL_DATA[g*DATA_W +: DATA_W] = chan_r[g];
   end

   assign CONV_START         = start_r;
   assign CONV_ABORT         = abort_r;
   assign ACTIVE_CHANNEL     = ch_r;
   assign CONV_RATE          = rate_r;
   assign CAL_START          = cal_go_r;
   assign CAL_KIND_OUT       = cal_kind_r;
   assign REGISTER_INDEX     = idx_r;
   assign REG_WRITE          = wr_r;
   assign REG_READ           = rd_r;
   assign RESULT_DATA        = data_r;
   assign CHANNEL_DONE_FLAGS = done_r;
   assign RESULT_READY_N     = rdy_n_r;
   assign LOW_POWER_REPORT   = lpr_r;
   assign MODULATOR_BUSY     = busy_r;
   assign OUTPUT_BIAS_PIN    = bias_r;
   assign OUTPUT_BIAS_PIN_OE = bias_oe_r;

endmodule

// file: acss_conv_model.sv
// Converter engine stand-in that answers conversion and calibration requests
`timescale 1ns/1ps
module acss_conv_model (
   // Requests and the latency asked of this job
   input  wire logic        clk, rst_b, conv_start, conv_abort, cal_start,
   input  wire logic [5:0]  lat,
   // Answers
   output logic             conv_done, cal_done,
   output logic [23:0]      conv_data, last_word
);
   int   cnt;
   logic conv_on, cal_on;
   // ------------------------------------------------------------
   // One job at a time; data toggles outside the done pulse
   // ------------------------------------------------------------
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         {cnt, conv_on, cal_on, conv_done, cal_done, conv_data} <= '0;
         last_word <= 24'h5A3C96;
      end else begin
         conv_done <= conv_on && cnt == 1;
         cal_done  <= cal_on && cnt == 1;
         conv_data <= (conv_on && cnt == 1) ? last_word + 24'h13579B : ~conv_data;
         if (conv_on && cnt == 1) last_word <= last_word + 24'h13579B;
         cnt <= (conv_start || cal_start) ? int'(lat) : (cnt > 0 ? cnt - 1 : 0);
         // An abort drops the pending result, as the real engine does
         if (conv_start || cal_start) {conv_on, cal_on} <= {conv_start, cal_start};
         else if (conv_abort || cnt == 1) {conv_on, cal_on} <= 2'h0;
      end
   end
endmodule

// file: acss_checker.sv
// Port checks of the command and scan sequencer
`timescale 1ns/1ps
module acss_checker (
   // Observed ports
   input wire logic       CLK, RST_B, CMD_VALID, SETTLE_DELAY_ENABLE, READY_AT_SCAN_END,
   input wire logic       ONE_SHOT_SELECT, REPEAT_ONE_SHOT, CONV_DONE, CONV_START, CAL_START,
   input wire logic       REG_WRITE, REG_READ, RESULT_READY_N, MODULATOR_BUSY,
   input wire logic [7:0] CMD_BYTE,
   input wire logic [4:0] REGISTER_INDEX,
   input wire logic [1:0] SCAN_MODE, POWER_DOWN_EXIT_STATE, CAL_KIND, CAL_KIND_OUT,
   input wire logic [1:0] LOW_POWER_REPORT, BIAS_PIN_CONTROL, OUTPUT_BIAS_PIN,
   input wire logic [1:0] BIAS_OUTPUT_DIRECTION, OUTPUT_BIAS_PIN_OE,
   input wire logic [5:0] CHANNEL_SCAN_ENABLE
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);
   // ------------------------------------------------------------
   // Command kinds and a finished conversion
   // ------------------------------------------------------------
   sequence seq_go; CMD_VALID && CMD_BYTE[7:4] == 4'hB; endsequence
   sequence conv_end; MODULATOR_BUSY && CONV_DONE && !CMD_VALID; endsequence
   reg_req_a: assert property (CMD_VALID && CMD_BYTE[7:6] == 2'h3 |=>
      REGISTER_INDEX == $past(CMD_BYTE[5:1]) && REG_READ == $past(CMD_BYTE[0]) &&
      REG_READ != REG_WRITE) else $error("register request wrong");
   // An empty scan goes straight to sleep, so it is left out here
   go_report_a: assert property (seq_go ##0
      (SCAN_MODE == 2'h0 || CHANNEL_SCAN_ENABLE != 6'h00) |=> LOW_POWER_REPORT == 2'h0)
      else $error("report not converting");
   go_start_a: assert property (seq_go ##0
      SCAN_MODE == 2'h0 && !SETTLE_DELAY_ENABLE |-> ##2 CONV_START && MODULATOR_BUSY)
      else $error("start late");
   pdown_a: assert property (CMD_VALID && CMD_BYTE[7:4] == 4'h9 |=>
      !MODULATOR_BUSY && LOW_POWER_REPORT ==
      ($past(POWER_DOWN_EXIT_STATE) == 2'h2 ? 2'h2 : 2'h1)) else $error("exit state");
   cal_go_a: assert property (CMD_VALID && CMD_BYTE[7:4] == 4'hA |=>
      CAL_START && CAL_KIND_OUT == $past(CAL_KIND)) else $error("calibration start");
   unused_op_a: assert property (CMD_VALID && CMD_BYTE[7:4] == 4'h8 &&
      LOW_POWER_REPORT != 2'h0 |=> $stable(LOW_POWER_REPORT) && !CAL_START)
      else $error("unused op acted");
   ready_a: assert property (conv_end ##0
      (SCAN_MODE == 2'h0 || !READY_AT_SCAN_END) |=> !RESULT_READY_N)
      else $error("ready missing");
   sleep_a: assert property (conv_end ##0
      SCAN_MODE == 2'h0 && ONE_SHOT_SELECT && !REPEAT_ONE_SHOT |=>
      LOW_POWER_REPORT == 2'h1 && !MODULATOR_BUSY) else $error("no sleep");
   busy_a: assert property ($rose(MODULATOR_BUSY) |-> CONV_START)
      else $error("busy early");
   bias_a: assert property (OUTPUT_BIAS_PIN == $past(BIAS_PIN_CONTROL) &&
      OUTPUT_BIAS_PIN_OE == $past(BIAS_OUTPUT_DIRECTION)) else $error("bias pin");
endmodule
bind adc_command_and_scan_sequencer acss_checker chk_u (.*);

// file: adc_command_and_scan_sequencer_bench.sv
// Random and corner-case bench of the command and scan sequencer
`timescale 1ns/1ps
module adc_command_and_scan_sequencer_bench;
   logic CLK, RST_B, CMD_VALID, SETTLE_DELAY_ENABLE, READY_AT_SCAN_END, ONE_SHOT_SELECT;
   logic REPEAT_ONE_SHOT, RESULT_READ, CONV_DONE, CAL_DONE, CONV_START, CONV_ABORT, CAL_START;
   logic REG_WRITE, REG_READ, RESULT_READY_N, MODULATOR_BUSY;
   logic [7:0]   CMD_BYTE, MUX_DELAY;
   logic [5:0]   CHANNEL_SCAN_ENABLE, CHANNEL_DONE_FLAGS, lat;
   logic [2:0]   INPUT_SELECTOR, ACTIVE_CHANNEL;
   logic [1:0]   SCAN_MODE, POWER_DOWN_EXIT_STATE, CAL_KIND, CAL_KIND_OUT, LOW_POWER_REPORT;
   logic [1:0]   BIAS_OUTPUT_DIRECTION, BIAS_PIN_CONTROL, OUTPUT_BIAS_PIN, OUTPUT_BIAS_PIN_OE;
   logic [3:0]   CONV_RATE, rate;
   logic [4:0]   REGISTER_INDEX;
   logic [17:0]  CHANNEL_ORDER_SLOT;
   logic [23:0]  CONV_DATA, RESULT_DATA, last_word;
   logic [143:0] CHANNEL_DATA;
   int err_total, samples_checked, seed, n, rot, ch, last_ch;
   adc_command_and_scan_sequencer dut_u (.*);
   acss_conv_model model_u (.clk(CLK), .rst_b(RST_B), .conv_start(CONV_START),
      .conv_abort(CONV_ABORT), .cal_start(CAL_START), .lat(lat), .conv_done(CONV_DONE),
      .cal_done(CAL_DONE), .conv_data(CONV_DATA), .last_word(last_word));
   // ------------------------------------------------------------
   // Clock, comparison, verdict, command and bounded wait
   // ------------------------------------------------------------
   initial begin
      CLK = 0;
      forever #20 CLK = ~CLK;
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task results;
      if (err_total == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Bias controls and engine latency change with every command
   task cmd(input logic [7:0] b);
      // An idle edge first, so valid is never lowered and raised in one step
      @(posedge CLK);
      #1 CMD_BYTE = b;
      CMD_VALID = 1;
      {BIAS_OUTPUT_DIRECTION, BIAS_PIN_CONTROL} = 4'($random(seed));
      lat = 6'($random(seed)) | 6'h1;
      @(posedge CLK);
      #1 CMD_VALID = 0;
   endtask
   // Kind 0 waits for a start, kind 1 for a low-power report
   task wait_ev(input int k);
      n = 0;
      do begin
         @(posedge CLK);
         #1 n++;
      end while (!(k == 0 ? CONV_START : LOW_POWER_REPORT != 2'h0) && n < 3000);
      if (n >= 3000) begin
         err_total++;
         results;
      end
   endtask
   initial begin
      {RST_B, CMD_VALID, SETTLE_DELAY_ENABLE, READY_AT_SCAN_END, ONE_SHOT_SELECT} = '0;
      {REPEAT_ONE_SHOT, RESULT_READ, CMD_BYTE, MUX_DELAY, CHANNEL_SCAN_ENABLE, lat} = '0;
      {INPUT_SELECTOR, SCAN_MODE, POWER_DOWN_EXIT_STATE, CAL_KIND, CHANNEL_ORDER_SLOT} = '0;
      {BIAS_OUTPUT_DIRECTION, BIAS_PIN_CONTROL, rate} = '0;
      {err_total, samples_checked, seed} = {32'h0, 32'h0, 32'h281b17a1};
      repeat (8) @(posedge CLK);
      #1 RST_B = 1;
      // Register requests back to back, then the unused operation
      repeat (6) begin
         n = $random(seed);
         cmd({2'h3, n[5:0]});
         chk({REGISTER_INDEX, REG_READ, REG_WRITE}, {n[5:0], ~n[0]});
      end
      cmd(8'h8F);
      chk({LOW_POWER_REPORT, MODULATOR_BUSY}, 3'h2);
      // Every calibration kind with its exit state
      for (int k = 0; k < 4; k++) begin
         {CAL_KIND, POWER_DOWN_EXIT_STATE} = {2'(k), 2'(k)};
         cmd(8'hA0);
         chk({CAL_START, CAL_KIND_OUT, LOW_POWER_REPORT}, {1'b1, 2'(k), 2'h0});
         wait_ev(1);
         chk(LOW_POWER_REPORT, k == 2 ? 2 : 1);
      end
      // Single channel one-shot, settle delay off and on
      for (int k = 0; k < 4; k++) begin
         {ONE_SHOT_SELECT, REPEAT_ONE_SHOT, SETTLE_DELAY_ENABLE} = {2'h2, k[0]};
         {MUX_DELAY, INPUT_SELECTOR, rate} = 15'($random(seed));
         cmd({4'hB, rate});
         chk({LOW_POWER_REPORT, CONV_RATE}, {2'h0, rate});
         wait_ev(0);
         chk(n, SETTLE_DELAY_ENABLE ? MUX_DELAY + 1 : 1);
         chk({ACTIVE_CHANNEL, MODULATOR_BUSY}, {INPUT_SELECTOR, 1'b1});
         wait_ev(1);
         chk({LOW_POWER_REPORT, MODULATOR_BUSY, RESULT_READY_N, RESULT_DATA},
            {4'h4, last_word});
         RESULT_READ = 1;
         @(posedge CLK);
         #1 RESULT_READ = 0;
         chk(RESULT_READY_N, 1);
      end
      // Continuous and repeated one-shot until power-down; host then picks a new channel
      for (int k = 0; k < 2; k++) begin
         {ONE_SHOT_SELECT, REPEAT_ONE_SHOT, SETTLE_DELAY_ENABLE} = {k[0], 2'h2};
         POWER_DOWN_EXIT_STATE = k ? 2'h0 : 2'h2;
         cmd({4'hB, rate});
         repeat (3) wait_ev(0);
         chk(LOW_POWER_REPORT, 0);
         cmd(8'h90);
         chk({LOW_POWER_REPORT, CONV_ABORT}, {k ? 2'h1 : 2'h2, 1'b1});
         INPUT_SELECTOR = 3'($random(seed)); // only after the exit report shows
      end
      // Scans over random channel sets in rotated slot order
      for (int k = 0; k < 3; k++) begin
         {SCAN_MODE, ONE_SHOT_SELECT, READY_AT_SCAN_END} = {2'(k + 1), 1'b1, k[0]};
         CHANNEL_SCAN_ENABLE = 6'($random(seed));
         rot = {$random(seed)} % 6;
         last_ch = -1;
         for (int g = 0; g < 6; g++) CHANNEL_ORDER_SLOT[g*3 +: 3] = 3'((g + rot) % 6 + 1);
         cmd(8'hB2);
         for (int s = 0; s < 6; s++) begin
            ch = (s - rot + 6) % 6;
            if (CHANNEL_SCAN_ENABLE[ch]) begin
               wait_ev(0);
               chk(ACTIVE_CHANNEL, ch);
               if (last_ch >= 0) chk(RESULT_READY_N, READY_AT_SCAN_END);
               last_ch = ch;
            end
         end
         wait_ev(1);
         chk({CHANNEL_DONE_FLAGS, RESULT_READY_N, LOW_POWER_REPORT},
            {CHANNEL_SCAN_ENABLE, CHANNEL_SCAN_ENABLE == 6'h0, 2'h1});
         if (last_ch >= 0) chk(CHANNEL_DATA[last_ch*24 +: 24], last_word);
      end
      results;
   end
endmodule
